// ### cbcs_sequencer.sv
// Machine cycle sequencer and multiplexed bus driver with APB control
`timescale 1ns/1ps
module cbcs_sequencer
   import cbcs_pkg::*;
(
   input  wire logic        mclk_i,
   input  wire logic        reset_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   input  wire logic        ready_i,
   input  wire logic        hold_i,
   input  wire logic        trap_i,
   input  wire logic        rst75_i,
   input  wire logic        rst65_i,
   input  wire logic        rst55_i,
   input  wire logic        intr_i,
   input  wire logic [7:0]  muxed_addr_data_lines_i,
   output logic             cpu_clk_o,
   output logic             hold_ack_o,
   output logic             status_bit_zero_o,
   output logic             status_bit_one_o,
   output logic             io_mem_sel_o,
   output logic             io_mem_sel_oe_o,
   output logic [7:0]       upper_address_lines_o,
   output logic             upper_address_oe_o,
   output logic [7:0]       muxed_addr_data_lines_o,
   output logic             muxed_addr_data_oe_o,
   output logic             rd_n_o,
   output logic             wr_n_o,
   output logic             strobe_oe_o,
   output logic             interrupt_ack_strobe_n_o,
   output logic             ale_o
);
   import cbcs_pkg::*;

   cbcs_state_e state;
   cbcs_state_e next_state;
   cbcs_cycle_e cmd_type;
   cbcs_cycle_e cur_type;
   cbcs_cycle_e ty;
   logic        cpu_clk;
   logic        fall_en;
   logic        cmd_pending;
   logic        cmd_noale;
   logic        cmd_first;
   logic        int_en;
   logic [2:0]  int_mask;
   logic [15:0] cmd_addr;
   logic [7:0]  cmd_wdata;
   logic [15:0] pc;
   logic [15:0] cur_addr;
   logic [15:0] ad16;
   logic [7:0]  cur_wdata;
   logic        cur_first;
   logic [7:0]  instr_reg;
   logic [7:0]  read_data;
   logic        hold_ack_flop;
   logic        rst75_prev;
   logic        rst75_latch;
   logic        pending_usable_irq;
   logic        acc;
   logic        wr_acc;
   logic        go_wr;
   logic        start_cycle;
   logic        end_state;
   logic        is_read;
   cbcs_state_e boundary;
   logic        next_s1;
   logic        next_s0;
   logic        next_sel;
   logic        next_sel_oe;
   logic        next_up_oe;
   logic [7:0]  next_ad;
   logic        next_ad_oe;
   logic        next_rd_n;
   logic        next_wr_n;
   logic        next_strb_oe;
   logic        next_interrupt_ack_strobe_n;
   logic        next_ale;

   // Single clock; the sequencer steps on the CPU clock fall enable
   cbcs_clk_div u_clk_div
   (
      .mclk_i    (mclk_i),
      .reset_i   (reset_i),
      .cpu_clk_o (cpu_clk),
      .fall_en_o (fall_en)
   );

   // Type and status encoding of each machine cycle
   function automatic logic [2:0] cyc_status(input cbcs_cycle_e t);
      case (t)
         CY_OF:   cyc_status = 3'h3;
         CY_MR:   cyc_status = 3'h2;
         CY_MW:   cyc_status = 3'h1;
         CY_IOR:  cyc_status = 3'h6;
         CY_IOW:  cyc_status = 3'h5;
         CY_INA:  cyc_status = 3'h7;
         default: cyc_status = 3'h2;
      endcase
   endfunction

   // APB access phase strobes; answer comes one cycle into access
   assign acc    = psel_i & penable_i & pready_o;
   assign wr_acc = acc & pwrite_i;
   assign go_wr  = wr_acc & (paddr_i == ADDR_CTRL) & pwdata_i[CTRL_GO];

   // Interrupt qualification; masks only cover the restart inputs
   assign pending_usable_irq = int_en & (trap_i | intr_i
      | (rst55_i & ~int_mask[0]) | (rst65_i & ~int_mask[1])
      | (rst75_latch & ~int_mask[2]));

   assign is_read  = (cur_type == CY_OF) | (cur_type == CY_MR) | (cur_type == CY_IOR);

   // Next machine cycle start, or halt, or hold
   assign boundary = hold_ack_flop ? ST_HOLD : (cmd_pending ? ST_T1 : ST_HALT);

   // State transition choice
   always_comb
   begin
      case (state)
         ST_RESET: next_state = ST_T1;
         ST_T1:    next_state = ST_T2;
         ST_T2:    next_state = ready_i ? ST_T3 : ST_WAIT;
         ST_WAIT:  next_state = ready_i ? ST_T3 : ST_WAIT;
         ST_T3:    next_state = cur_first ? ST_T4 : boundary;
         ST_T4:    next_state = ((instr_reg & DEC_PAIR_MASK) == DEC_PAIR_VAL)
                                ? ST_T5 : boundary;
         ST_T5:    next_state = ST_T6;
         ST_T6:    next_state = boundary;
         ST_HALT:  next_state = boundary;
         ST_HOLD:  next_state = hold_i ? ST_HOLD : (cmd_pending ? ST_T1 : ST_HALT);
         default:  next_state = ST_RESET;
      endcase
   end

   assign start_cycle = fall_en & (next_state == ST_T1);
   assign end_state   = fall_en & (state == ST_T3);

   // Type and address seen by the pins in the coming state
   assign ty   = (next_state == ST_T1) ? cmd_type : cur_type;
   assign ad16 = (next_state == ST_T1)
                 ? (((cmd_type == CY_OF) | (cmd_type == CY_INA)) ? pc : cmd_addr)
                 : cur_addr;

   // Pin values for the coming state
   always_comb
   begin
      {next_sel, next_s1, next_s0} = cyc_status(ty);
      next_sel_oe  = 1'b1;
      next_up_oe   = 1'b1;
      next_ad      = ad16[7:0];
      next_ad_oe   = 1'b0;
      next_rd_n    = 1'b1;
      next_wr_n    = 1'b1;
      next_strb_oe = 1'b1;
      next_interrupt_ack_strobe_n  = 1'b1;
      next_ale     = 1'b0;
      case (next_state)
         ST_T1:
         begin
            next_ad_oe = 1'b1;
            next_ale   = ~cmd_noale;
         end
         ST_T2, ST_WAIT, ST_T3:
         begin
            // Identical in wait so the bus is frozen as in state two
            next_ad    = cur_wdata;
            next_ad_oe = (ty == CY_MW) | (ty == CY_IOW);
            next_wr_n  = ~((ty == CY_MW) | (ty == CY_IOW));
            next_rd_n  = ~((ty == CY_OF) | (ty == CY_MR) | (ty == CY_IOR));
            next_interrupt_ack_strobe_n = ~(ty == CY_INA);
         end
         ST_T4, ST_T5, ST_T6:
         begin
            next_s1  = 1'b1;
            next_s0  = 1'b1;
            next_sel = (ty == CY_INA) | ((instr_reg & RST_MASK) == RST_VAL);
         end
         default:
         begin
            // Reset, halt and hold release the shared lines
            next_sel_oe  = 1'b0;
            next_up_oe   = 1'b0;
            next_strb_oe = 1'b0;
            next_s1      = 1'b0;
            next_s0      = 1'b0;
         end
      endcase
   end

   // Machine state register
   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
         state <= ST_RESET;
      else if (fall_en)
         state <= next_state;
   end

   // Pin flops, updated only at the CPU clock fall
   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         status_bit_one_o         <= 1'b0;
         status_bit_zero_o        <= 1'b0;
         io_mem_sel_o             <= 1'b0;
         io_mem_sel_oe_o          <= 1'b0;
         upper_address_lines_o    <= 8'h00;
         upper_address_oe_o       <= 1'b0;
         muxed_addr_data_lines_o  <= 8'h00;
         muxed_addr_data_oe_o     <= 1'b0;
         rd_n_o                   <= 1'b1;
         wr_n_o                   <= 1'b1;
         strobe_oe_o              <= 1'b0;
         interrupt_ack_strobe_n_o <= 1'b1;
         ale_o                    <= 1'b0;
      end
      else if (fall_en)
      begin
         status_bit_one_o         <= next_s1;
         status_bit_zero_o        <= next_s0;
         io_mem_sel_o             <= next_sel;
         io_mem_sel_oe_o          <= next_sel_oe;
         upper_address_lines_o    <= ad16[15:8];
         upper_address_oe_o       <= next_up_oe;
         muxed_addr_data_lines_o  <= next_ad;
         muxed_addr_data_oe_o     <= next_ad_oe;
         rd_n_o                   <= next_rd_n;
         wr_n_o                   <= next_wr_n;
         strobe_oe_o              <= next_strb_oe;
         interrupt_ack_strobe_n_o <= next_interrupt_ack_strobe_n;
         ale_o                    <= next_ale;
      end
   end

   // Current cycle capture and program counter step as a fetch starts
   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         cur_type  <= CY_OF;
         cur_addr  <= 16'h0000;
         cur_wdata <= 8'h00;
         cur_first <= 1'b1;
         pc        <= PC_RESET;
      end
      else
      begin
         if (start_cycle)
         begin
            cur_type  <= cmd_type;
            cur_addr  <= ad16;
            cur_wdata <= cmd_wdata;
            cur_first <= (cmd_type == CY_OF) | cmd_first;
         end
         if (start_cycle & (cmd_type == CY_OF))
            pc <= pc + 16'h0001;
         else if (wr_acc & (paddr_i == ADDR_PC))
            pc <= pwdata_i[15:0];
      end
   end

   // Data captured at the end of state three, strobe then rises
   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         instr_reg <= 8'h00;
         read_data <= 8'h00;
      end
      else if (end_state & (is_read | (cur_type == CY_INA)))
      begin
         read_data <= muxed_addr_data_lines_i;
         if (cur_first)
            instr_reg <= muxed_addr_data_lines_i;
      end
   end

   // Hold acknowledge: set in states two to five, wait or halt, takes effect next state
   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
         hold_ack_flop <= 1'b0;
      else if (fall_en)
      begin
         if (state == ST_HOLD)
            hold_ack_flop <= hold_i;
         else if (hold_i & ((state == ST_T2) | (state == ST_WAIT) | (state == ST_T3)
                  | (state == ST_T4) | (state == ST_T5) | (state == ST_HALT)))
            hold_ack_flop <= 1'b1;
      end
   end
   assign hold_ack_o = hold_ack_flop;

   // Restart 7.5 edge latch; a new edge beats a clear
   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         rst75_prev  <= 1'b0;
         rst75_latch <= 1'b0;
      end
      else
      begin
         rst75_prev <= rst75_i;
         if (rst75_i & ~rst75_prev)
            rst75_latch <= 1'b1;
         else if (wr_acc & (paddr_i == ADDR_CTRL) & pwdata_i[CTRL_CLR75])
            rst75_latch <= 1'b0;
      end
   end

   // Command registers; a go write beats the consume at cycle start
   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         cmd_pending <= 1'b1;
         cmd_type    <= CY_OF;
         cmd_noale   <= 1'b0;
         cmd_first   <= 1'b0;
         int_en      <= 1'b0;
         int_mask    <= 3'h7;
         cmd_addr    <= 16'h0000;
         cmd_wdata   <= 8'h00;
      end
      else
      begin
         if (go_wr)
            cmd_pending <= 1'b1;
         else if (start_cycle)
            cmd_pending <= 1'b0;
         if (wr_acc & (paddr_i == ADDR_CTRL))
         begin
            cmd_type  <= cbcs_cycle_e'(pwdata_i[CTRL_TYPE_LSB +: 3]);
            cmd_noale <= pwdata_i[CTRL_NOALE];
            int_en    <= pwdata_i[CTRL_INTEN];
            int_mask  <= pwdata_i[CTRL_MASK_LSB +: 3];
            cmd_first <= pwdata_i[CTRL_FIRST];
         end
         if (wr_acc & (paddr_i == ADDR_ADDR))
            cmd_addr <= pwdata_i[15:0];
         if (wr_acc & (paddr_i == ADDR_WDATA))
            cmd_wdata <= pwdata_i[7:0];
      end
   end

   // APB answer: one wait cycle so read data comes from a flop
   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o  <= 32'h0000_0000;
      end
      else
      begin
         pready_o  <= psel_i & penable_i & ~pready_o;
         pslverr_o <= 1'b0;
         prdata_o  <= 32'h0000_0000;
         if (psel_i & penable_i & ~pready_o)
         begin
            if (paddr_i == ADDR_CTRL)
               prdata_o <= {22'h0, cmd_first, int_mask, int_en, 1'b0, cmd_noale,
                            cmd_type};
            else if (paddr_i == ADDR_ADDR)
               prdata_o <= {16'h0, cmd_addr};
            else if (paddr_i == ADDR_WDATA)
               prdata_o <= {24'h0, cmd_wdata};
            else if (paddr_i == ADDR_PC)
               prdata_o <= {16'h0, pc};
            else if (paddr_i == ADDR_STATUS)
               prdata_o <= {18'h0, rst75_latch, pending_usable_irq, hold_ack_flop,
                            cmd_pending, state};
            else if (paddr_i == ADDR_DATA)
               prdata_o <= {16'h0, read_data, instr_reg};
            else
               pslverr_o <= 1'b1;
         end
      end
   end

   assign cpu_clk_o = cpu_clk;
endmodule // cbcs_sequencer

// ### cbcs_pkg.sv
// Package of constants and types for the bus cycle sequencer
package cbcs_pkg;
   // Machine states, one-hot
   typedef enum logic [9:0]
   {
      ST_T1    = 10'h001,
      ST_T2    = 10'h002,
      ST_WAIT  = 10'h004,
      ST_T3    = 10'h008,
      ST_T4    = 10'h010,
      ST_T5    = 10'h020,
      ST_T6    = 10'h040,
      ST_RESET = 10'h080,
      ST_HALT  = 10'h100,
      ST_HOLD  = 10'h200
   } cbcs_state_e;

   // Machine cycle types
   typedef enum logic [2:0]
   {
      CY_OF  = 3'h0,
      CY_MR  = 3'h1,
      CY_MW  = 3'h2,
      CY_IOR = 3'h3,
      CY_IOW = 3'h4,
      CY_INA = 3'h5,
      CY_BI  = 3'h6
   } cbcs_cycle_e;

   // CPU clock: 40 MHz master divided by two half periods
   localparam int unsigned CLK_HALF_CYCLES = 1;

   // APB byte addresses
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_ADDR   = 8'h04;
   localparam logic [7:0] ADDR_WDATA  = 8'h08;
   localparam logic [7:0] ADDR_PC     = 8'h0C;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   localparam logic [7:0] ADDR_DATA   = 8'h14;

   // Control register fields
   localparam int unsigned CTRL_TYPE_LSB = 0;
   localparam int unsigned CTRL_NOALE    = 3;
   localparam int unsigned CTRL_GO       = 4;
   localparam int unsigned CTRL_INTEN    = 5;
   localparam int unsigned CTRL_MASK_LSB = 6;
   localparam int unsigned CTRL_FIRST    = 9;
   localparam int unsigned CTRL_CLR75    = 10;

   // Status register fields
   localparam int unsigned STAT_PEND   = 10;
   localparam int unsigned STAT_HLDA   = 11;
   localparam int unsigned STAT_IRQ    = 12;
   localparam int unsigned STAT_LAT75  = 13;

   // Opcode decode patterns
   localparam logic [7:0] DEC_PAIR_MASK = 8'hCF;
   localparam logic [7:0] DEC_PAIR_VAL  = 8'h0B;
   localparam logic [7:0] RST_MASK      = 8'hC7;
   localparam logic [7:0] RST_VAL       = 8'hC7;

   // Values after reset
   localparam logic [15:0] PC_RESET = 16'h0000;
endpackage

// ### cbcs_clk_div.sv
// CPU clock divider with falling-edge enable pulse
`timescale 1ns/1ps
module cbcs_clk_div
   import cbcs_pkg::*;
(
   input  wire logic mclk_i,
   input  wire logic reset_i,
   output logic      cpu_clk_o,
   output logic      fall_en_o
);
   logic [7:0] half_cnt;
   logic       half_end;

   assign half_end  = (half_cnt == 8'(CLK_HALF_CYCLES - 1));
   // Pulse in the master cycle whose edge drops the CPU clock
   assign fall_en_o = half_end & cpu_clk_o;

   // Half period counter and clock toggle
   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         half_cnt  <= 8'h00;
         cpu_clk_o <= 1'b0;
      end
      else if (half_end)
      begin
         half_cnt  <= 8'h00;
         cpu_clk_o <= ~cpu_clk_o;
      end
      else
      begin
         half_cnt <= half_cnt + 8'h01;
      end
   end
endmodule // cbcs_clk_div

// ### cbcs_monitor.sv
// Checker of sequencer pin relations over time
`timescale 1ns/1ps
module cbcs_monitor (
   input wire logic       mclk_i,
   input wire logic       reset_i,
   input wire logic       cpu_clk_o,
   input wire logic       hold_ack_o,
   input wire logic       status_bit_zero_o,
   input wire logic       status_bit_one_o,
   input wire logic       io_mem_sel_o,
   input wire logic       io_mem_sel_oe_o,
   input wire logic [7:0] upper_address_lines_o,
   input wire logic       upper_address_oe_o,
   input wire logic       muxed_addr_data_oe_o,
   input wire logic       rd_n_o,
   input wire logic       wr_n_o,
   input wire logic       strobe_oe_o,
   input wire logic       interrupt_ack_strobe_n_o,
   input wire logic       ale_o
);
   default clocking dc @(posedge mclk_i);
   endclocking
   default disable iff (reset_i);
   // Pins move only with a CPU clock fall
   pin_edge_a: assert property (
      $changed({ale_o, rd_n_o, wr_n_o, status_bit_one_o}) |-> $fell(cpu_clk_o))
      else $error("pin moved off a cpu clock fall");
   // Latch strobe opens the cycle for exactly one state
   ale_setup_a: assert property (
      $rose(ale_o) |-> muxed_addr_data_oe_o && upper_address_oe_o && rd_n_o && wr_n_o)
      else $error("latch strobe without address driven");
   ale_width_a: assert property (
      $rose(ale_o) |=> ale_o ##1 !ale_o)
      else $error("latch strobe not one state long");
   ad_turn_a: assert property (
      $fell(ale_o) && !rd_n_o |-> !muxed_addr_data_oe_o)
      else $error("low address held into read");
   // Read strobe span keeps pins frozen, catches wait states too
   wait_hold_a: assert property (
      !rd_n_o && $past(!rd_n_o) |-> $stable(upper_address_lines_o)
         && $stable({status_bit_one_o, status_bit_zero_o, io_mem_sel_o})
         && !muxed_addr_data_oe_o && !ale_o)
      else $error("pins moved during read strobe");
   read_mark_a: assert property (
      !rd_n_o |-> status_bit_one_o && wr_n_o && interrupt_ack_strobe_n_o)
      else $error("read strobe with wrong marks");
   write_mark_a: assert property (
      !wr_n_o |-> !status_bit_one_o && status_bit_zero_o && muxed_addr_data_oe_o && rd_n_o)
      else $error("write strobe with wrong marks");
   interrupt_ack_strobe_mark_a: assert property (
      !interrupt_ack_strobe_n_o |-> io_mem_sel_o && status_bit_one_o && status_bit_zero_o)
      else $error("acknowledge strobe with wrong marks");
   // Halt, hold and reset float the bus, select and strobes; status and latch strobe driven low
   idle_float_a: assert property (
      !strobe_oe_o |-> !status_bit_one_o && !status_bit_zero_o && !ale_o
         && interrupt_ack_strobe_n_o && !muxed_addr_data_oe_o && !upper_address_oe_o
         && !io_mem_sel_oe_o)
      else $error("idle state with a pin driven");
   hold_float_a: assert property (
      $rose(hold_ack_o) |-> ##[1:40] (!upper_address_oe_o && !strobe_oe_o))
      else $error("bus not released after hold ack");
endmodule // cbcs_monitor

bind cbcs_sequencer cbcs_monitor cbcs_monitor_i (.mclk_i(mclk_i), .reset_i(reset_i),
   .cpu_clk_o(cpu_clk_o), .hold_ack_o(hold_ack_o), .status_bit_zero_o(status_bit_zero_o),
   .status_bit_one_o(status_bit_one_o), .io_mem_sel_o(io_mem_sel_o),
   .io_mem_sel_oe_o(io_mem_sel_oe_o), .upper_address_lines_o(upper_address_lines_o),
   .upper_address_oe_o(upper_address_oe_o), .muxed_addr_data_oe_o(muxed_addr_data_oe_o),
   .rd_n_o(rd_n_o), .wr_n_o(wr_n_o), .strobe_oe_o(strobe_oe_o),
   .interrupt_ack_strobe_n_o(interrupt_ack_strobe_n_o), .ale_o(ale_o));

// ### cbcs_mem_model.sv
// Memory and port model on the shared address/data bus
`timescale 1ns/1ps
module cbcs_mem_model (
   input  wire logic        mclk_i,
   input  wire logic        reset_i,
   input  wire logic        cpu_clk_i,
   input  wire logic        ale_i,
   input  wire logic        ad_oe_i,
   input  wire logic [7:0]  ad_i,
   input  wire logic [7:0]  upper_i,
   input  wire logic        rd_n_i,
   input  wire logic        wr_n_i,
   input  wire logic        interrupt_ack_strobe_n_i,
   input  wire logic [7:0]  rd_byte_i,
   input  wire logic [3:0]  waits_i,
   output logic      [7:0]  ad_level_o,
   output logic             ready_o,
   output logic      [15:0] addr_o,
   output logic      [7:0]  wr_byte_o
);
   logic       clk_q;
   logic [3:0] cnt;
   logic [7:0] last;
   // Device drives only under its strobe; released bus drifts
   assign ad_level_o = ad_oe_i ? ad_i : (!rd_n_i || !interrupt_ack_strobe_n_i) ? rd_byte_i : ~last;
   assign ready_o = (cnt == 4'h0);
   // Address latch on strobe, wait count down per CPU clock fall
   always_ff @(posedge mclk_i)
   begin
      clk_q <= cpu_clk_i;
      last <= ad_level_o;
      if (reset_i)
         cnt <= 4'h0;
      else if (ale_i)
         cnt <= waits_i + 4'h1;
      else if (clk_q && !cpu_clk_i && cnt != 4'h0)
         cnt <= cnt - 4'h1;
      if (ale_i && ad_oe_i)
         addr_o <= {upper_i, ad_i};
      if (!wr_n_i)
         wr_byte_o <= ad_level_o;
   end
endmodule // cbcs_mem_model

// ### tb_top.sv
// Self-checking bench for the bus cycle sequencer
`timescale 1ns/1ps
module tb_top;
   import cbcs_pkg::*;
   logic        mclk_i = 1'b0, reset_i = 1'b1;
   logic        psel = 1'b0, pen = 1'b0, pwr = 1'b0, hold = 1'b0, rst55 = 1'b0;
   logic        intr = 1'b0, trap = 1'b0, rst75 = 1'b0, rst65 = 1'b0, rerr;
   logic [7:0]  paddr = 8'h00, rd_byte = 8'h00, ad_lvl, ad_out, upper, wbyte;
   logic [31:0] pwdata = 32'h0, prdata, rdata;
   logic [15:0] maddr, pc;
   logic [3:0]  waits = 4'h0;
   logic [2:0]  cap;
   logic        pready, pslverr, ready, cclk, hack, s0, s1, sel, sel_oe, up_oe;
   logic        ad_oe, rd_n, wr_n, stb_oe, interrupt_ack_strobe_n, ale;
   int          failures = 0, checks_done = 0, ale_cnt = 0, rd_low = 0, s11 = 0;
   logic [2:0]  mark_tab [0:6] = '{3'h3, 3'h2, 3'h1, 3'h6, 3'h5, 3'h7, 3'h2};
   logic [31:0] dec_ctl [0:3] = '{32'h201, 32'h1, 32'h9, 32'h0};
   int          dec_s11 [0:3] = '{6, 0, 0, 12};
   int          dec_ale [0:3] = '{2, 2, 0, 2};
   logic [31:0] irq_ctl [0:3] = '{32'h1E0, 32'h20, 32'h0, 32'h1E0};
   logic [3:0]  irq_tab [0:3] = '{4'h1, 4'h5, 4'h2, 4'h7};

   always #12.5 mclk_i = ~mclk_i;

   cbcs_sequencer cbcs_sequencer_i (.mclk_i(mclk_i), .reset_i(reset_i), .psel_i(psel),
      .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .ready_i(ready),
      .hold_i(hold), .trap_i(trap), .rst75_i(rst75), .rst65_i(rst65), .rst55_i(rst55),
      .intr_i(intr), .muxed_addr_data_lines_i(ad_lvl), .cpu_clk_o(cclk),
      .hold_ack_o(hack), .status_bit_zero_o(s0), .status_bit_one_o(s1),
      .io_mem_sel_o(sel), .io_mem_sel_oe_o(sel_oe), .upper_address_lines_o(upper),
      .upper_address_oe_o(up_oe), .muxed_addr_data_lines_o(ad_out),
      .muxed_addr_data_oe_o(ad_oe), .rd_n_o(rd_n), .wr_n_o(wr_n), .strobe_oe_o(stb_oe),
      .interrupt_ack_strobe_n_o(interrupt_ack_strobe_n), .ale_o(ale));
   cbcs_mem_model cbcs_mem_model_i (.mclk_i(mclk_i), .reset_i(reset_i), .cpu_clk_i(cclk),
      .ale_i(ale), .ad_oe_i(ad_oe), .ad_i(ad_out), .upper_i(upper), .rd_n_i(rd_n),
      .wr_n_i(wr_n), .interrupt_ack_strobe_n_i(interrupt_ack_strobe_n), .rd_byte_i(rd_byte), .waits_i(waits),
      .ad_level_o(ad_lvl), .ready_o(ready), .addr_o(maddr), .wr_byte_o(wbyte));

   // Marks at each latch strobe, and strobe and status counters
   always @(posedge mclk_i)
   begin
      if (ale === 1'b1)
      begin
         cap = {sel, s1, s0};
         ale_cnt++;
      end
      if (rd_n === 1'b0)
         rd_low++;
      if ({s1, s0} === 2'b11)
         s11++;
   end

   task give_verdict;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp)
      begin
         failures++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask

   // Bounded wait exhausted counts as a mismatch and ends the run
   task bound(input int n, input int lim);
      if (n >= lim)
      begin
         failures++;
         give_verdict();
      end
   endtask

   // One APB transfer, held until pready is sampled high
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwr <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk_i);
      pen <= 1'b1;
      n = 0;
      do
      begin
         @(posedge mclk_i);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      bound(n, 20);
      @(posedge mclk_i);
   endtask

   // Optionally queue a cycle, then poll until halted and idle
   task run(input logic go, input logic [31:0] ctl);
      int n;
      if (go)
         apb(1'b1, ADDR_CTRL, ctl | (32'h1 << CTRL_GO));
      n = 0;
      do
      begin
         apb(1'b0, ADDR_STATUS, 32'h0);
         n++;
      end
      while (!(rdata[8] === 1'b1 && rdata[STAT_PEND] === 1'b0) && n < 100);
      bound(n, 100);
   endtask

   initial
   begin
      repeat (10) @(posedge mclk_i);
      check("reset enables", 4'h0, {ad_oe, up_oe, stb_oe, sel_oe});
      check("reset strobes", 2'b01, {ale, interrupt_ack_strobe_n});
      repeat (6) @(posedge mclk_i);
      reset_i <= 1'b0;
      run(1'b0, 32'h0);
      check("first fetch address", 16'h0000, maddr);
      check("first fetch marks", 3'h3, cap);
      check("four state fetch", 8, s11);
      apb(1'b0, ADDR_PC, 32'h0);
      check("counter after fetch", 32'h1, rdata);
      $display("test reset fetch done");
      pc = 16'h0001;
      for (int t = 0; t < 7; t++)
      begin
         rd_byte <= 8'h40 + t;
         apb(1'b1, ADDR_ADDR, 32'h3C00 + t * 17);
         apb(1'b1, ADDR_WDATA, 32'h90 + t);
         run(1'b1, (t == 5) ? 32'h205 : t);
         check("cycle marks", mark_tab[t], cap);
         check("address", (t == 0 || t == 5) ? pc : 16'h3C00 + t * 17, maddr);
         apb(1'b0, ADDR_DATA, 32'h0);
         if (t == 1 || t == 3)
            check("read data", 8'h40 + t, rdata[15:8]);
         if (t == 0 || t == 5)
            check("opcode", 8'h40 + t, rdata[7:0]);
         if (t == 2 || t == 4)
            check("write data", 8'h90 + t, wbyte);
         if (t == 0)
            pc++;
      end
      $display("test cycle types done");
      for (int w = 0; w < 3; w++)
      begin
         waits <= w;
         rd_low = 0;
         run(1'b1, CY_MR);
         check("read strobe length", 4 + 2 * w, rd_low);
      end
      waits <= 4'h0;
      $display("test wait states done");
      for (int k = 0; k < 4; k++)
      begin
         rd_byte <= 8'h2B;
         s11 = 0;
         ale_cnt = 0;
         run(1'b1, dec_ctl[k]);
         check("status one-one span", dec_s11[k], s11);
         check("latch strobe span", dec_ale[k], ale_cnt);
      end
      $display("test decode done");
      for (int k = 0; k < 4; k++)
      begin
         apb(1'b1, ADDR_CTRL, irq_ctl[k]);
         rst55 <= irq_tab[k][0];
         intr <= irq_tab[k][1];
         repeat (6) @(posedge mclk_i);
         apb(1'b0, ADDR_STATUS, 32'h0);
         check("usable irq", irq_tab[k][2], rdata[STAT_IRQ]);
      end
      rst55 <= 1'b0;
      intr <= 1'b0;
      rst75 <= 1'b1;
      apb(1'b1, ADDR_CTRL, 32'h20);
      apb(1'b0, ADDR_STATUS, 32'h0);
      check("edge latch and irq", 2'b11, rdata[13:12]);
      apb(1'b1, ADDR_CTRL, 32'h420);
      apb(1'b0, ADDR_STATUS, 32'h0);
      check("edge latch cleared", 1'b0, rdata[STAT_LAT75]);
      apb(1'b1, ADDR_CTRL, 32'h1C0);
      $display("test interrupts done");
      hold <= 1'b1;
      repeat (20) @(posedge mclk_i);
      check("hold enables", 4'h0, {ad_oe, up_oe, stb_oe, sel_oe});
      apb(1'b0, ADDR_STATUS, 32'h0);
      check("hold status", 3'h5, rdata[11:9]);
      hold <= 1'b0;
      run(1'b0, 32'h0);
      $display("test hold done");
      apb(1'b0, 8'h40, 32'h0);
      check("unmapped error", 1'b1, rerr);
      check("unmapped data", 32'h0, rdata);
      $display("test unmapped done");
      give_verdict();
   end
endmodule // tb_top
